/* clk_align_pkg.sv */
// shared constants for the sample clock phase and delay control block
package clk_align_pkg;

  localparam int ADDR_W = 16;
  localparam int DATA_W = 8;

  // register offsets
  localparam logic [15:0] ADDR_PHASE  = 16'h0109;
  localparam logic [15:0] ADDR_ALIGN  = 16'h010A;
  localparam logic [15:0] ADDR_MODE   = 16'h0110;
  localparam logic [15:0] ADDR_SUPER  = 16'h0111;
  localparam logic [15:0] ADDR_FINE   = 16'h0112;
  localparam logic [15:0] ADDR_STATUS = 16'h01F0;

  // reset values
  localparam logic [7:0] RST_PHASE = 8'h00;
  localparam logic [7:0] RST_ALIGN = 8'h00;
  localparam logic [7:0] RST_MODE  = 8'h00;
  localparam logic [7:0] RST_SUPER = 8'h00;
  localparam logic [7:0] RST_FINE  = 8'hC0;

  // writable bit masks
  localparam logic [7:0] MASK_PHASE = 8'h0F;
  localparam logic [7:0] MASK_ALIGN = 8'h8F;
  localparam logic [7:0] MASK_MODE  = 8'h07;

  // field positions
  localparam int AUTO_BIT = 7;
  localparam int NEG_LO   = 2;
  localparam int POS_LO   = 0;
  localparam int INWIN_BIT   = 0;
  localparam int REALIGN_BIT = 1;

  // delay mode codes
  localparam logic [2:0] MODE_NONE        = 3'h0;
  localparam logic [2:0] MODE_RSVD_A      = 3'h1;
  localparam logic [2:0] MODE_FINE16      = 3'h2;
  localparam logic [2:0] MODE_FINE16_LJ   = 3'h3;
  localparam logic [2:0] MODE_FINE192     = 3'h4;
  localparam logic [2:0] MODE_RSVD_B      = 3'h5;
  localparam logic [2:0] MODE_FINE_SUPER  = 3'h6;

  // step sizes in femtoseconds
  localparam int          DELAY_FS_W    = 19;
  localparam logic [18:0] FINE_STEP_FS  = 19'h006BD;
  localparam logic [18:0] SUPER_STEP_FS = 19'h000FA;

  // divider phase taps: whole input cycles 0..7
  localparam int TAP_DEPTH = 8;
  localparam int TAP_SEL_W = 3;

  typedef enum logic [1:0] {
    SR_LOW  = 2'b01,
    SR_HIGH = 2'b10
  } sysref_state_type;

endpackage : clk_align_pkg

/* delay_taps.sv */
// tapped shift register delaying a one-cycle tick by a selectable count
`timescale 1ns/1ps
module delay_taps #(
  parameter int DEPTH = 8,
  parameter int SEL_W = 3
) (
  input  wire logic             clk,
  input  wire logic             rst_b,
  input  wire logic             d,
  input  wire logic [SEL_W-1:0] sel,
  output logic                  q_ff
);
  logic [DEPTH-1:0] chain_ff;
  logic [DEPTH-1:0] nxt_chain;
  logic             nxt_q;

  genvar gi;
  generate
    for (gi = 0; gi < DEPTH; gi++) begin : g_stage
      if (gi == 0) begin : g_head
        always_comb nxt_chain[gi] = d;
      end else begin : g_body
        always_comb nxt_chain[gi] = chain_ff[gi-1];
      end
    end
  endgenerate

  always_comb begin
    nxt_q = chain_ff[sel];
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      chain_ff <= '0;
      q_ff     <= 1'b0;
    end else begin
      chain_ff <= nxt_chain;
      q_ff     <= nxt_q;
    end
  end
endmodule : delay_taps

/* sample_clock_phase_delay_ctrl.sv */
// sample clock divider phase, sysref alignment and delay mode control
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module sample_clock_phase_delay_ctrl (
  input  wire logic                                 ref_clk,
  input  wire logic                                 rst_b,
  input  wire logic [clk_align_pkg::ADDR_W-1:0]     reg_addr,
  input  wire logic [clk_align_pkg::DATA_W-1:0]     reg_wdata,
  input  wire logic                                 reg_wr,
  input  wire logic                                 reg_rd,
  output logic      [clk_align_pkg::DATA_W-1:0]     reg_rdata,
  input  wire logic                                 sysref_pin,
  input  wire logic [3:0]                           div_ratio,
  output logic                                      dev_clk_tick,
  output logic                                      dev_clk_invert,
  output logic                                      align_pulse,
  output logic      [7:0]                           fine_steps,
  output logic      [7:0]                           super_fine_steps,
  output logic                                      low_jitter_sel,
  output logic      [clk_align_pkg::DELAY_FS_W-1:0] sample_delay_fs
);
  import clk_align_pkg::*;

  // register file
  logic [7:0] phase_ff, align_ff, mode_ff, super_ff, fine_ff, rdata_ff;
  logic [7:0] nxt_phase, nxt_align, nxt_mode, nxt_super, nxt_fine;
  logic [7:0] nxt_rdata;
  logic [7:0] status_rd;

  always_comb begin
    nxt_phase = phase_ff;
    nxt_align = align_ff;
    nxt_mode  = mode_ff;
    nxt_super = super_ff;
    nxt_fine  = fine_ff;
    if (reg_wr) begin
      unique case (reg_addr)
        ADDR_PHASE: nxt_phase = reg_wdata & MASK_PHASE;
        ADDR_ALIGN: nxt_align = reg_wdata & MASK_ALIGN;
        ADDR_MODE:  nxt_mode  = reg_wdata & MASK_MODE;
        ADDR_SUPER: nxt_super = reg_wdata;
        ADDR_FINE:  nxt_fine  = reg_wdata;
        default:    nxt_phase = phase_ff;
      endcase
    end
    nxt_rdata = 8'h00;
    if (reg_rd) begin
      unique case (reg_addr)
        ADDR_PHASE:  nxt_rdata = phase_ff;
        ADDR_ALIGN:  nxt_rdata = align_ff;
        ADDR_MODE:   nxt_rdata = mode_ff;
        ADDR_SUPER:  nxt_rdata = super_ff;
        ADDR_FINE:   nxt_rdata = fine_ff;
        ADDR_STATUS: nxt_rdata = status_rd;
        default:     nxt_rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      phase_ff <= RST_PHASE;
      align_ff <= RST_ALIGN;
      mode_ff  <= RST_MODE;
      super_ff <= RST_SUPER;
      fine_ff  <= RST_FINE;
      rdata_ff <= 8'h00;
    end else begin
      phase_ff <= nxt_phase;
      align_ff <= nxt_align;
      mode_ff  <= nxt_mode;
      super_ff <= nxt_super;
      fine_ff  <= nxt_fine;
      rdata_ff <= nxt_rdata;
    end
  end

  assign reg_rdata = rdata_ff;

  // sysref pin: three stages, a level counts once stages two and three agree
  logic [2:0]       sr_sync_ff;
  sysref_state_type sr_state_ff, nxt_sr_state;
  logic             capture;

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sr_sync_ff <= 3'h0;
    end else begin
      sr_sync_ff <= {sr_sync_ff[1:0], sysref_pin};
    end
  end

  // one capture per sysref rising level, no retrigger while high
  always_comb begin
    nxt_sr_state = sr_state_ff;
    capture      = 1'b0;
    unique case (sr_state_ff)
      SR_LOW: begin
        if (sr_sync_ff[1] && sr_sync_ff[2]) begin
          capture      = 1'b1;
          nxt_sr_state = SR_HIGH;
        end
      end
      SR_HIGH: begin
        if (!sr_sync_ff[1] && !sr_sync_ff[2]) begin
          nxt_sr_state = SR_LOW;
        end
      end
      default: nxt_sr_state = SR_LOW;
    endcase
  end

  // divider phase counter and skew window check
  logic [3:0] cnt_ff, nxt_cnt, div_eff, cnt_inc;
  logic [5:0] late_half, early_half, pos_tol, neg_tol;
  logic       in_window, tick_raw, realign;
  logic       inwin_ff, nxt_inwin, realigned_ff, nxt_realigned;
  logic       pulse_ff, nxt_pulse;

  always_comb begin
    div_eff  = (div_ratio == 4'h0) ? 4'h1 : div_ratio;
    cnt_inc  = cnt_ff + 4'h1;
    tick_raw = (cnt_ff == 4'h0);
    // error in half input cycles; a half device clock is div_eff of them
    late_half  = {1'b0, cnt_ff, 1'b0};
    early_half = {1'b0, 4'(div_eff - cnt_ff), 1'b0};
    // widen before the product: code 3 at divide by 8 needs five bits
    pos_tol    = 6'(align_ff[POS_LO +: 2]) * 6'(div_eff);
    neg_tol    = 6'(align_ff[NEG_LO +: 2]) * 6'(div_eff);
    // code 00 on both sides leaves only an exact hit in window
    in_window  = tick_raw || (late_half <= pos_tol)
                 || (early_half <= neg_tol);
    realign    = capture && align_ff[AUTO_BIT] && !in_window;
    nxt_cnt    = (cnt_inc >= div_eff) ? 4'h0 : cnt_inc;
    if (realign) begin
      // the capture cycle becomes phase zero
      nxt_cnt = (div_eff == 4'h1) ? 4'h0 : 4'h1;
    end
    nxt_inwin     = capture ? in_window : inwin_ff;
    nxt_realigned = capture ? realign : realigned_ff;
    nxt_pulse     = realign;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      sr_state_ff  <= SR_LOW;
      cnt_ff       <= 4'h0;
      inwin_ff     <= 1'b0;
      realigned_ff <= 1'b0;
      pulse_ff     <= 1'b0;
    end else begin
      sr_state_ff  <= nxt_sr_state;
      cnt_ff       <= nxt_cnt;
      inwin_ff     <= nxt_inwin;
      realigned_ff <= nxt_realigned;
      pulse_ff     <= nxt_pulse;
    end
  end

  assign align_pulse = pulse_ff;
  assign status_rd   = {6'h00, realigned_ff, inwin_ff};

  // phase offset: whole cycles via taps, the half cycle as clock invert
  logic invert_ff, nxt_invert;

  delay_taps #(
    .DEPTH (TAP_DEPTH),
    .SEL_W (TAP_SEL_W)
  ) u_taps (
    .clk   (ref_clk),
    .rst_b (rst_b),
    .d     (tick_raw),
    .sel   (phase_ff[3:1]),
    .q_ff  (dev_clk_tick)
  );

  always_comb nxt_invert = phase_ff[0];

  // delay mode gating
  logic [7:0]            fine_out_ff, super_out_ff, nxt_fine_out;
  logic [7:0]            nxt_super_out;
  logic                  lj_ff, nxt_lj;
  logic [DELAY_FS_W-1:0] delay_ff, nxt_delay;

  always_comb begin
    nxt_fine_out  = 8'h00;
    nxt_super_out = 8'h00;
    // reserved codes fall through to no delay, so 1 and 5 match
    unique case (mode_ff[2:0])
      MODE_FINE16, MODE_FINE16_LJ, MODE_FINE192:
        nxt_fine_out = fine_ff;
      MODE_FINE_SUPER: begin
        nxt_fine_out  = fine_ff;
        nxt_super_out = super_ff;
      end
      default: nxt_fine_out = 8'h00;
    endcase
    if (mode_ff[2:0] == MODE_FINE16) begin
      nxt_super_out = super_ff;
    end
    nxt_lj    = (mode_ff[2:0] == MODE_FINE16_LJ);
    nxt_delay = nxt_fine_out * FINE_STEP_FS
                + nxt_super_out * SUPER_STEP_FS;
  end

  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      invert_ff    <= 1'b0;
      fine_out_ff  <= 8'h00;
      super_out_ff <= 8'h00;
      lj_ff        <= 1'b0;
      delay_ff     <= '0;
    end else begin
      invert_ff    <= nxt_invert;
      fine_out_ff  <= nxt_fine_out;
      super_out_ff <= nxt_super_out;
      lj_ff        <= nxt_lj;
      delay_ff     <= nxt_delay;
    end
  end

  assign dev_clk_invert   = invert_ff;
  assign fine_steps       = fine_out_ff;
  assign super_fine_steps = super_out_ff;
  assign low_jitter_sel   = lj_ff;
  assign sample_delay_fs  = delay_ff;

  a_phase_six: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (tick_raw && phase_ff == 4'hC) ##1 (phase_ff == 4'hC) [*7]
      |-> ##1 dev_clk_tick) else $error("six cycle phase delay wrong");
  a_phase_half: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (phase_ff == 4'hF) [*2] |-> dev_clk_invert)
    else $error("half cycle invert missing");
  a_auto_off: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (capture && !align_ff[AUTO_BIT]) |=> !align_pulse)
    else $error("realign while auto adjust off");
  a_exact_window: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (capture && align_ff == 8'h80 && cnt_ff != 4'h0)
      |=> align_pulse && (cnt_ff == 4'h1))
    else $error("exact capture not realigned");
  a_neg_window: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (capture && align_ff == 8'h8C && div_eff == 4'h8 && cnt_ff == 4'h3)
      |=> !align_pulse) else $error("early sysref not tolerated");
  a_pos_window: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (capture && align_ff == 8'h82 && div_eff == 4'h8 && cnt_ff == 4'h3)
      |=> !align_pulse) else $error("late sysref not tolerated");
  a_mode_none: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mode_ff == 8'h01 || mode_ff == 8'h05 || mode_ff == 8'h00)
      |=> fine_steps == 8'h00 && super_fine_steps == 8'h00)
    else $error("delay applied in no-delay mode");
  a_fine_full: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mode_ff == 8'h04) |=> fine_steps == $past(fine_ff)
      && super_fine_steps == 8'h00) else $error("mode four gating wrong");
  a_super_gate: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (mode_ff != 8'h02 && mode_ff != 8'h06) |=> super_fine_steps == 8'h00)
    else $error("super fine used outside its modes");
  a_delay_sum: assert property (@(posedge ref_clk) disable iff (!rst_b)
    sample_delay_fs == 19'(fine_steps * FINE_STEP_FS
      + super_fine_steps * SUPER_STEP_FS)) else $error("delay sum wrong");
  a_reserved_zero: assert property (@(posedge ref_clk) disable iff (!rst_b)
    (reg_rd && reg_addr == ADDR_ALIGN) |=> reg_rdata[6:4] == 3'h0)
    else $error("reserved bits read nonzero");

endmodule : sample_clock_phase_delay_ctrl

/* sysref_source.sv */
// sysref timing source model driving the converter's sysref pin
`timescale 1ns/1ps
module sysref_source #(
  parameter int HIGH_CYCLES = 6
) (
  input  wire logic ref_clk,
  input  wire logic rst_b,
  input  wire logic fire,
  output logic      sysref_pin
);
  int count_ff;
  // one clean pulse per request, long enough for a three-flop synchroniser
  always @(posedge ref_clk) begin
    if (!rst_b) begin
      sysref_pin <= 1'b0;
      count_ff   <= 0;
    end else if (fire) begin
      sysref_pin <= 1'b1;
      count_ff   <= HIGH_CYCLES;
    end else if (count_ff > 1) begin
      count_ff <= count_ff - 1;
    end else begin
      sysref_pin <= 1'b0;
      count_ff   <= 0;
    end
  end
endmodule : sysref_source

/* testbench.sv */
// self-checking bench for the sample clock phase and delay control block
`timescale 1ns/1ps
module testbench;
  import clk_align_pkg::*;
  logic                  ref_clk, rst_b, reg_wr, reg_rd, fire;
  logic [15:0]           reg_addr;
  logic [7:0]            reg_wdata, reg_rdata, fine_steps, super_fine_steps;
  logic                  sysref_pin, dev_clk_tick, dev_clk_invert;
  logic                  align_pulse, low_jitter_sel;
  logic [DELAY_FS_W-1:0] sample_delay_fs;
  int                    num_errors, comparisons, base, pos;
  int                    cyc = 0;
  logic [7:0]            ef, es;
  logic [15:0] addrs [4] = '{ADDR_PHASE, ADDR_ALIGN, ADDR_MODE, ADDR_SUPER};
  logic [7:0]  masks [4] = '{MASK_PHASE, MASK_ALIGN, MASK_MODE, 8'hFF};
  logic [7:0]  ctls [7] = '{8'h00, 8'h80, 8'h82, 8'h83, 8'h88, 8'h8C, 8'h80};
  logic        rea [7]  = '{1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1};

  sample_clock_phase_delay_ctrl u_sample_clock_phase_delay_ctrl (
    .ref_clk(ref_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .sysref_pin(sysref_pin), .div_ratio(4'h8),
    .dev_clk_tick(dev_clk_tick), .dev_clk_invert(dev_clk_invert),
    .align_pulse(align_pulse), .fine_steps(fine_steps),
    .super_fine_steps(super_fine_steps), .low_jitter_sel(low_jitter_sel),
    .sample_delay_fs(sample_delay_fs)
  );
  sysref_source u_sysref_source (
    .ref_clk(ref_clk), .rst_b(rst_b), .fire(fire), .sysref_pin(sysref_pin)
  );

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) cyc <= cyc + 1;

  task automatic final_report;
    if (num_errors == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask : check

  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, e);
  endtask : rd

  // position of the next divided tick within the 8-cycle divider period
  task automatic tick_at(output int p);
    p = -1;
    for (int n = 0; n < 24 && p < 0; n++) begin
      @(posedge ref_clk);
      #1;
      if (dev_clk_tick === 1'b1) p = cyc % 8;
    end
    if (p < 0) begin
      num_errors++;
      final_report();
    end
  endtask : tick_at

  // sysref lands three input cycles past the phase zero point
  task automatic sync_try(input logic [7:0] ctl, input logic realign);
    int seen;
    seen = 0;
    wr(ADDR_ALIGN, ctl);
    tick_at(base);
    repeat (5) @(posedge ref_clk);
    fire <= 1'b1;
    @(posedge ref_clk);
    fire <= 1'b0;
    repeat (12) begin
      @(posedge ref_clk);
      #1;
      if (align_pulse === 1'b1) seen++;
    end
    check(seen, realign);
    tick_at(pos);
    check(pos != base, realign);
    if (ctl[7]) rd(ADDR_STATUS, {6'h00, realign, ~realign});
  endtask : sync_try

  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 16'h0000;
    reg_wdata = 8'h00;
    fire = 1'b0;
    num_errors = 0;
    comparisons = 0;
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(ADDR_PHASE, RST_PHASE);
    rd(ADDR_ALIGN, RST_ALIGN);
    rd(ADDR_MODE, RST_MODE);
    rd(ADDR_SUPER, RST_SUPER);
    rd(ADDR_FINE, RST_FINE);
    for (int i = 0; i < 4; i++) begin
      wr(addrs[i], 8'hFF);
      rd(addrs[i], masks[i]);
      wr(addrs[i], 8'h00);
    end
    wr(16'h0000, 8'h5A);
    rd(16'h0000, 8'h00);
    wr(ADDR_FINE, 8'h10);
    wr(ADDR_SUPER, 8'h80);
    for (int m = 0; m < 8; m++) begin
      wr(ADDR_MODE, m[7:0]);
      repeat (3) @(posedge ref_clk);
      #1;
      ef = (m inside {2, 3, 4, 6}) ? 8'h10 : 8'h00;
      es = (m == 2 || m == 6) ? 8'h80 : 8'h00;
      check(fine_steps, ef);
      check(super_fine_steps, es);
      check(low_jitter_sel, m == 3);
      check(sample_delay_fs, ef * FINE_STEP_FS + es * SUPER_STEP_FS);
    end
    wr(ADDR_FINE, 8'hC0);
    wr(ADDR_MODE, 8'h06);
    repeat (3) @(posedge ref_clk);
    #1;
    check(sample_delay_fs, 192 * 1725 + 128 * 250);
    wr(ADDR_MODE, 8'h00);
    tick_at(base);
    for (int p = 12; p < 16; p++) begin
      wr(ADDR_PHASE, p[7:0]);
      repeat (16) @(posedge ref_clk);
      tick_at(pos);
      check((pos - base + 8) % 8, (p / 2) % 8);
      check(dev_clk_invert, p % 2);
    end
    wr(ADDR_PHASE, 8'h00);
    for (int k = 0; k < 7; k++) sync_try(ctls[k], rea[k]);
    final_report();
  end
endmodule : testbench
